//--- logic/irq_mode_device.sv
// Device end: interrupt status, masking, mode and vector logic
`timescale 1ns/1ps
`default_nettype none
module irq_mode_device (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    irq_link_if.device link,
    input wire logic [irq_mode_pkg::SRC_W-1:0] status_set,
    input wire logic [irq_mode_pkg::SRC_W-1:0] status_clear,
    input wire logic mask_wr,
    input wire logic [irq_mode_pkg::SRC_W-1:0] mask_wdata,
    input wire logic vector_wr,
    input wire logic [irq_mode_pkg::VEC_W-1:0] vector_wdata,
    input wire logic set_vectored_cmd,
    output logic [irq_mode_pkg::SRC_W-1:0] raw_interrupt_status,
    output logic [irq_mode_pkg::SRC_W-1:0] masked_interrupt_status,
    output logic [irq_mode_pkg::VEC_W-1:0] vector_rdata,
    output logic vectored_mode
);
    import irq_mode_pkg::*;
    // Sources are tx ready, rx ready, timer, break change and port change only;
    // receive errors have no input here and no pin to reach
    logic [SRC_W-1:0] status_q, mask_q, masked_q;
    logic [VEC_W-1:0] vector_q;
    irq_mode_t mode_q;
    logic ack_s1_q, ack_s2_q, prio_s1_q, prio_s2_q;
    logic irq_q, oe_q, prio_out_q;
    logic [VEC_W-1:0] dout_q;
    logic [SRC_W-1:0] status_d;

    // Set wins over a same-cycle clear so no event is lost
    assign status_d = (status_q & ~status_clear) | status_set;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= STATUS_RESET;
        end else if (clk_en) begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= MASK_RESET;
        end else if (clk_en && mask_wr) begin
            mask_q <= mask_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            masked_q <= STATUS_RESET;
            irq_q <= 1'b1;
        end else if (clk_en) begin
            masked_q <= status_d & (mask_wr ? mask_wdata : mask_q);
            irq_q <= ~|(status_d & (mask_wr ? mask_wdata : mask_q));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_q <= VECTOR_RESET;
        end else if (clk_en && vector_wr) begin
            vector_q <= vector_wdata;
        end
    end

    // Only reset leaves vectored mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_NONVECTORED;
        end else if (clk_en && set_vectored_cmd) begin
            mode_q <= MODE_VECTORED;
        end
    end

    // Acknowledge and priority-in come from another party: two-stage sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1_q <= 1'b1;
            ack_s2_q <= 1'b1;
            prio_s1_q <= 1'b0;
            prio_s2_q <= 1'b0;
        end else if (clk_en) begin
            ack_s1_q <= link.host_acknowledge_n;
            ack_s2_q <= ack_s1_q;
            prio_s1_q <= link.prio_in;
            prio_s2_q <= prio_s1_q;
        end
    end

    // Answers an acknowledge only when vectored, requesting, and granted priority
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
            dout_q <= VECTOR_RESET;
            prio_out_q <= 1'b0;
        end else if (clk_en) begin
            oe_q <= (mode_q == MODE_VECTORED) && !ack_s2_q && prio_s2_q && !irq_q;
            dout_q <= vector_q;
            prio_out_q <= prio_s2_q && (irq_q || mode_q != MODE_VECTORED);
        end
    end

    assign link.irq_out_n = irq_q;
    assign link.data_out = dout_q;
    assign link.data_oe = oe_q;
    assign link.prio_out = prio_out_q;
    assign raw_interrupt_status = status_q;
    assign masked_interrupt_status = masked_q;
    assign vector_rdata = vector_q;
    assign vectored_mode = (mode_q == MODE_VECTORED);
endmodule
`default_nettype wire

//--- logic/irq_mode_pkg.sv
// Shared constants and types for the interrupt mode logic and its host end
`default_nettype none
package irq_mode_pkg;
    localparam int SRC_W = 8;
    localparam int VEC_W = 8;
    localparam int TX_A_BIT = 0;
    localparam int RX_A_BIT = 1;
    localparam int BRK_A_BIT = 2;
    localparam int TIMER_BIT = 3;
    localparam int TX_B_BIT = 4;
    localparam int RX_B_BIT = 5;
    localparam int BRK_B_BIT = 6;
    localparam int INPORT_BIT = 7;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] VECTOR_RESET = 8'h0F;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    typedef enum logic {MODE_NONVECTORED, MODE_VECTORED} irq_mode_t;
    typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_ACK} host_state_t;
endpackage
`default_nettype wire

//--- logic/irq_link_if.sv
// Link between the interrupt logic and the host interrupt logic
`timescale 1ns/1ps
`default_nettype none
interface irq_link_if;
    logic irq_out_n;
    logic host_acknowledge_n;
    logic [7:0] data_out;
    logic data_oe;
    logic prio_in;
    logic prio_out;
    modport device (output irq_out_n, output data_out, output data_oe, output prio_out,
                    input host_acknowledge_n, input prio_in);
    modport host (input irq_out_n, input data_out, input data_oe, input prio_out,
                  output host_acknowledge_n, output prio_in);
endinterface
`default_nettype wire

//--- logic/irq_mode_host.sv
// Host end: sees the request, runs acknowledge cycles in vectored use
`timescale 1ns/1ps
`default_nettype none
module irq_mode_host #(
    parameter int ACK_CYCLES = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    irq_link_if.host link,
    input wire logic use_vectoring,
    input wire logic prio_grant,
    output logic irq_pending,
    output logic vector_valid,
    output logic [7:0] vector_value
);
    import irq_mode_pkg::*;
    host_state_t state_q;
    logic irq_s1_q, irq_s2_q, oe_s1_q, oe_s2_q, ack_n_q, prio_q, pend_q, vv_q;
    logic [7:0] d_s1_q, d_s2_q, vec_q;
    logic [7:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_s1_q <= 1'b1;
            irq_s2_q <= 1'b1;
            oe_s1_q <= 1'b0;
            oe_s2_q <= 1'b0;
            d_s1_q <= 8'h00;
            d_s2_q <= 8'h00;
        end else if (clk_en) begin
            irq_s1_q <= link.irq_out_n;
            irq_s2_q <= irq_s1_q;
            oe_s1_q <= link.data_oe;
            oe_s2_q <= oe_s1_q;
            d_s1_q <= link.data_out;
            d_s2_q <= d_s1_q;
        end
    end

    // Without vectoring the request is simply serviced, no acknowledge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HS_IDLE;
            ack_n_q <= 1'b1;
            cnt_q <= 8'h00;
            vv_q <= 1'b0;
            vec_q <= 8'h00;
        end else if (clk_en) begin
            vv_q <= 1'b0;
            case (state_q)
                HS_IDLE: begin
                    if (!irq_s2_q && use_vectoring) begin
                        state_q <= HS_ACK;
                        ack_n_q <= 1'b0;
                        cnt_q <= 8'h00;
                    end
                end
                HS_ACK: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (oe_s2_q) begin
                        vec_q <= d_s2_q;
                        vv_q <= 1'b1;
                    end
                    if (oe_s2_q || cnt_q == 8'(ACK_CYCLES)) begin
                        ack_n_q <= 1'b1;
                        state_q <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    // Hold off until the request drops so one event gives one cycle
                    if (irq_s2_q) begin
                        state_q <= HS_IDLE;
                    end
                end
                default: state_q <= HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (clk_en) begin
            prio_q <= prio_grant;
            pend_q <= !irq_s2_q;
        end
    end

    assign link.host_acknowledge_n = ack_n_q;
    assign link.prio_in = prio_q;
    assign irq_pending = pend_q;
    assign vector_valid = vv_q;
    assign vector_value = vec_q;
endmodule
`default_nettype wire

//--- verification/irq_link_assertions.sv
// Concurrent checks on the link between the device and host interrupt ends
`timescale 1ns/1ps
`default_nettype none
module irq_link_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irq_out_n,
    input wire logic host_acknowledge_n,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic prio_in,
    input wire logic prio_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Grant withheld long enough to clear the synchroniser and the output register
    sequence s_no_grant;
        !prio_in [*6];
    endsequence
    a_reset_quiet: assert property ($rose(rst_n) |-> irq_out_n && !data_oe) else $error("busy after reset");
    a_oe_cause: assert property ($rose(data_oe) |-> !$past(host_acknowledge_n, 3) && $past(prio_in, 3)
        && !$past(irq_out_n)) else $error("vector without request");
    a_vec_stable: assert property (data_oe && $past(data_oe) |-> $stable(data_out)) else $error("vector moved");
    a_claim_blocks: assert property (data_oe |-> !prio_out) else $error("grant passed while claiming");
    a_chain_idle: assert property (s_no_grant |-> !prio_out) else $error("grant passed without grant");
    a_oe_release: assert property ($rose(host_acknowledge_n) |-> ##[1:4] !data_oe) else $error("vector held");
    a_ack_ends: assert property ($rose(data_oe) |-> ##[1:8] host_acknowledge_n) else $error("ack held");
    a_ack_bound: assert property ($fell(host_acknowledge_n) |-> ##[1:16] host_acknowledge_n) else $error("ack stuck");
endmodule
`default_nettype wire

//--- verification/tb.sv
// Testbench joining the device and host interrupt ends
`timescale 1ns/1ps
`default_nettype none
module tb;
    import irq_mode_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, mask_wr = 1'b0, vector_wr = 1'b0;
    logic set_vectored_cmd = 1'b0, use_vectoring = 1'b0, prio_grant = 1'b0;
    logic [7:0] status_set = 8'h00, status_clear = 8'h00, mask_wdata = 8'h00, vector_wdata = 8'h00;
    logic [7:0] raw_interrupt_status, masked_interrupt_status, vector_rdata, vector_value, irq8;
    logic vectored_mode, irq_pending, vector_valid;
    int error_cnt = 0, samples_checked = 0;
    irq_link_if link();
    irq_mode_device i_irq_mode_device (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .link(link),
        .status_set(status_set),
        .status_clear(status_clear),
        .mask_wr(mask_wr),
        .mask_wdata(mask_wdata),
        .vector_wr(vector_wr),
        .vector_wdata(vector_wdata),
        .set_vectored_cmd(set_vectored_cmd),
        .raw_interrupt_status(raw_interrupt_status),
        .masked_interrupt_status(masked_interrupt_status),
        .vector_rdata(vector_rdata),
        .vectored_mode(vectored_mode)
    );
    irq_mode_host i_irq_mode_host (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .link(link),
        .use_vectoring(use_vectoring),
        .prio_grant(prio_grant),
        .irq_pending(irq_pending),
        .vector_valid(vector_valid),
        .vector_value(vector_value)
    );
    irq_link_assertions i_irq_link_assertions (.clk, .rst_n, .irq_out_n(link.irq_out_n),
        .host_acknowledge_n(link.host_acknowledge_n), .data_out(link.data_out), .data_oe(link.data_oe),
        .prio_in(link.prio_in), .prio_out(link.prio_out));
    assign irq8 = {7'h00, link.irq_out_n};
    initial forever #2.5 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Strobes last one cycle; status and request are registered, so give them time to land
    task automatic step(input logic [7:0] s, input logic [7:0] c, input logic [2:0] st);
        {status_set, status_clear, mask_wr, vector_wr, set_vectored_cmd} = {s, c, st};
        cyc(1);
        {status_set, status_clear, mask_wr, vector_wr, set_vectored_cmd} = 19'h0_0000;
        cyc(3);
    endtask
    task automatic t_after_reset();
        check("irq", irq8, 8'h01);
        check("mode", 8'(vectored_mode), 8'h00);
        check("vec", vector_rdata, VECTOR_RESET);
    endtask
    // A held-off clock enable must keep every status bit where it was
    task automatic t_freeze();
        clk_en = 1'b0;
        status_set = 8'h10;
        cyc(3);
        check("frozen", raw_interrupt_status, 8'h00);
        status_set = 8'h00;
        clk_en = 1'b1;
        cyc(1);
    endtask
    task automatic t_sources();
        mask_wdata = 8'h01;
        vector_wdata = 8'hA5;
        step(8'h02, 8'h00, 3'b110);
        check("raw", raw_interrupt_status, 8'h02);
        check("msk", masked_interrupt_status, 8'h00);
        check("irq", irq8, 8'h01);
        check("vec", vector_rdata, 8'hA5);
        mask_wdata = 8'hFF;
        step(8'h00, 8'h02, 3'b100);
        for (int i = 0; i < SRC_W; i++) begin
            step(8'h01 << i, 8'h00, 3'b000);
            check("msk", masked_interrupt_status, 8'h01 << i);
            check("irq", irq8, 8'h00);
            step(8'h00, 8'h01 << i, 3'b000);
            check("irq", irq8, 8'h01);
        end
    endtask
    task automatic t_nonvectored();
        step(8'h08, 8'h00, 3'b000);
        {use_vectoring, prio_grant} = 2'b11;
        repeat (20) @(negedge clk) check("oe", 8'(link.data_oe), 8'h00);
        check("pend", 8'(irq_pending), 8'h01);
        check("chain", 8'(link.prio_out), 8'h01);
        use_vectoring = 1'b0;
        // Clearing the cause lets the host leave its wait state
        step(8'h00, 8'h08, 3'b000);
        cyc(3);
        check("pend", 8'(irq_pending), 8'h00);
    endtask
    task automatic t_vectored();
        step(8'h08, 8'h00, 3'b001);
        check("mode", 8'(vectored_mode), 8'h01);
        use_vectoring = 1'b1;
        repeat (40) if (vector_valid !== 1'b1) cyc(1);
        check("valid", 8'(vector_valid), 8'h01);
        if (vector_valid !== 1'b1) print_verdict();
        check("vec", vector_value, 8'hA5);
        use_vectoring = 1'b0;
        step(8'h00, 8'h08, 3'b000);
        cyc(4);
        check("chain", 8'(link.prio_out), 8'h01);
        check("mode", 8'(vectored_mode), 8'h01);
    endtask
    initial begin
        cyc(12);
        rst_n = 1'b1;
        cyc(2);
        t_after_reset();
        t_freeze();
        t_sources();
        t_nonvectored();
        t_vectored();
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        t_after_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
